// [hw/cbx_params.svh]
`ifndef CBX_PARAMS_SVH
`define CBX_PARAMS_SVH

// ****************************************************************
// Register offsets and field positions
// ****************************************************************
`define CBX_OFF_CTRL 8'h00
`define CBX_OFF_STATUS 8'h04
`define CBX_OFF_PC 8'h08
`define CBX_OFF_WORK 8'h0C
`define CBX_OFF_IR 8'h10
`define CBX_CTRL_RUN 0
`define CBX_CTRL_BANK_LO 8
`define CBX_ST_ZERO 0
`define CBX_ST_OVF 1
`define CBX_ST_NEG 2
`define CBX_ST_PWRDN 3
`define CBX_ST_TMOUT 4

// ****************************************************************
// Reset values
// ****************************************************************
`define CBX_RST_PC 16'h0000
`define CBX_RST_BANK 4'h0
`define CBX_RST_TMOUT 1'b1
`define CBX_RST_PWRDN 1'b1

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CBX_OPC_JNOV 8'hE5
`define CBX_OPC_JNZ 8'hE1
`define CBX_PFX_JRA 5'h1A
`define CBX_PFX_BSET 4'h8
`define CBX_PFX_TSC 4'hB
`define CBX_PFX_TSS 4'hA
`define CBX_PFX_CPL 6'h07
`define CBX_WORD_WDC 16'h0004
`define CBX_PFX_MOVE2 4'hC
`define CBX_PFX_LONG 6'h3B

// ****************************************************************
// Addressing and sequencing constants
// ****************************************************************
`define CBX_ACC_HIGH_BANK 4'hF
`define CBX_ACC_LOW_BANK 4'h0
`define CBX_FETCH_STEP 16'h0002

`endif

// [hw/cbx_pkg.sv]
`include "cbx_params.svh"

package cbx_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		CBX_Q1 = 4'b0001,
		CBX_Q2 = 4'b0010,
		CBX_Q3 = 4'b0100,
		CBX_Q4 = 4'b1000
	} cbx_phase_t;

	typedef enum logic [3:0] {
		CBX_OP_NONE = 4'h0,
		CBX_OP_JNOV = 4'h1,
		CBX_OP_JNZ = 4'h2,
		CBX_OP_JRA = 4'h3,
		CBX_OP_BSET = 4'h4,
		CBX_OP_TSC = 4'h5,
		CBX_OP_TSS = 4'h6,
		CBX_OP_WDC = 4'h7,
		CBX_OP_CPL = 4'h8
	} cbx_op_t;

	typedef struct packed {
		cbx_op_t op;
		logic [10:0] offset;
		logic [2:0] bit_idx;
		logic bank_bit;
		logic dest;
		logic [7:0] faddr;
	} cbx_dec_t;

	typedef struct packed {
		cbx_phase_t phase;
		logic run;
		logic [3:0] bank;
		logic [15:0] pc;
		logic [15:0] ir;
		logic nop;
		logic kill;
		logic [7:0] work;
		logic zero;
		logic ovf;
		logic neg;
		logic pwrdn;
		logic tmout;
		logic take;
		logic skip;
		logic [11:0] faddr;
		logic frd;
		logic fwr;
		logic [7:0] fwdata;
		logic wdclr;
		logic ready;
		logic slverr;
		logic [31:0] prdata;
	} cbx_state_t;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic two_word(input logic [15:0] w);
		return (w[15:12] == `CBX_PFX_MOVE2) || (w[15:10] == `CBX_PFX_LONG);
	endfunction

	function automatic logic uses_file(input cbx_op_t op);
		return (op == CBX_OP_BSET) || (op == CBX_OP_TSC) || (op == CBX_OP_TSS) || (op == CBX_OP_CPL);
	endfunction

endpackage

// [hw/cbx_decode.sv]
`timescale 1ns/1ps
`include "cbx_params.svh"

module cbx_decode (
	// Instruction word
	input wire logic [15:0] word,
	input wire logic valid,
	// Decoded fields
	output cbx_pkg::cbx_dec_t dec
);

	always_comb begin
		dec = '0;
		dec.bit_idx = word[11:9];
		dec.bank_bit = word[8];
		dec.dest = word[9];
		dec.faddr = word[7:0];
		dec.offset = {{3{word[7]}}, word[7:0]};
		dec.op = cbx_pkg::CBX_OP_NONE;
		if (!valid) begin
			dec.op = cbx_pkg::CBX_OP_NONE;
		end else if (word[15:8] == `CBX_OPC_JNOV) begin
			dec.op = cbx_pkg::CBX_OP_JNOV;
		end else if (word[15:8] == `CBX_OPC_JNZ) begin
			dec.op = cbx_pkg::CBX_OP_JNZ;
		end else if (word[15:11] == `CBX_PFX_JRA) begin
			dec.op = cbx_pkg::CBX_OP_JRA;
			dec.offset = word[10:0];
		end else if (word[15:12] == `CBX_PFX_BSET) begin
			dec.op = cbx_pkg::CBX_OP_BSET;
		end else if (word[15:12] == `CBX_PFX_TSC) begin
			dec.op = cbx_pkg::CBX_OP_TSC;
		end else if (word[15:12] == `CBX_PFX_TSS) begin
			dec.op = cbx_pkg::CBX_OP_TSS;
		end else if (word == `CBX_WORD_WDC) begin
			dec.op = cbx_pkg::CBX_OP_WDC;
		end else if (word[15:10] == `CBX_PFX_CPL) begin
			dec.op = cbx_pkg::CBX_OP_CPL;
		end
	end

endmodule

// [hw/cbx_core.sv]
// Functional notes
// - Opcode E5 with offset jumps only when the overflow flag is zero.
// - Opcode E1 with offset jumps only when the zero flag is clear.
// - Conditional jump target is jump address plus two plus twice signed offset.
// - Conditional jump: one cycle untaken, two when taken, second cycle idle.
// - Prefix 11010 with 11-bit offset always jumps, two cycles, flags kept.
// - Prefix 1000 sets the indexed bit of the addressed file register.
// - Bank bit zero selects access bank, one uses bank select register.
// - Prefix 1011 skips the fetched next instruction when tested bit is zero.
// - Prefix 1010 skips the fetched next instruction when tested bit is one.
// - Skip costs one extra cycle, two when the skipped instruction has two words.
// - Word 0004 clears watchdog and postscaler, sets timeout and power-down flags.
// - Prefix 000111 complements the file register into working or file register.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "cbx_params.svh"

module cbx_core (
	// Clock, reset and clock enable
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	// APB register slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Program fetch
	output logic [15:0] PROG_ADDR,
	input wire logic [15:0] PROG_DATA,
	// Data file
	output logic [11:0] FILE_ADDR,
	output logic FILE_RD_EN,
	input wire logic [7:0] FILE_RD_DATA,
	output logic FILE_WR_EN,
	output logic [7:0] FILE_WR_DATA,
	// Watchdog
	output logic WATCHDOG_CLEAR
);

	// ****************************************************************
	// State and decode
	// ****************************************************************
	cbx_pkg::cbx_state_t s;
	cbx_pkg::cbx_state_t next_s;
	cbx_pkg::cbx_dec_t dec;
	logic [15:0] disp;
	logic [15:0] jump_target;
	logic [7:0] mask;
	logic [11:0] file_addr;
	logic [2:0] flags;
	logic apb_done;

	cbx_decode u_decode (
		.word(s.ir),
		.valid(!s.nop),
		.dec(dec)
	);

	// Doubling the offset is folded into the shift; the fetch has already moved one word on.
	assign disp = {{4{dec.offset[10]}}, dec.offset, 1'b0};
	assign jump_target = s.pc + disp;
	assign mask = 8'h01 << dec.bit_idx;
	assign file_addr = {(dec.bank_bit ? s.bank : (dec.faddr[7] ? `CBX_ACC_HIGH_BANK : `CBX_ACC_LOW_BANK)),
		dec.faddr};
	assign flags = {s.zero, s.ovf, s.neg};
	assign apb_done = PSEL && PENABLE && s.ready;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_s = s;
		if (PSEL && PENABLE && !s.ready) begin
			next_s.ready = 1'b1;
			next_s.slverr = 1'b0;
			next_s.prdata = '0;
			case (PADDR)
				`CBX_OFF_CTRL: begin
					next_s.prdata[`CBX_CTRL_RUN] = s.run;
					next_s.prdata[`CBX_CTRL_BANK_LO +: 4] = s.bank;
				end
				`CBX_OFF_STATUS: begin
					next_s.prdata[`CBX_ST_ZERO] = s.zero;
					next_s.prdata[`CBX_ST_OVF] = s.ovf;
					next_s.prdata[`CBX_ST_NEG] = s.neg;
					next_s.prdata[`CBX_ST_PWRDN] = s.pwrdn;
					next_s.prdata[`CBX_ST_TMOUT] = s.tmout;
				end
				`CBX_OFF_PC: next_s.prdata[15:0] = s.pc;
				`CBX_OFF_WORK: next_s.prdata[7:0] = s.work;
				`CBX_OFF_IR: next_s.prdata[15:0] = s.ir;
				default: next_s.slverr = 1'b1;
			endcase
		end else if (s.ready) begin
			next_s.ready = 1'b0;
			next_s.slverr = 1'b0;
			if (apb_done && PWRITE && !s.slverr) begin
				case (PADDR)
					`CBX_OFF_CTRL: begin
						next_s.run = PWDATA[`CBX_CTRL_RUN];
						next_s.bank = PWDATA[`CBX_CTRL_BANK_LO +: 4];
					end
					`CBX_OFF_STATUS: begin
						next_s.zero = PWDATA[`CBX_ST_ZERO];
						next_s.ovf = PWDATA[`CBX_ST_OVF];
						next_s.neg = PWDATA[`CBX_ST_NEG];
						next_s.pwrdn = PWDATA[`CBX_ST_PWRDN];
						next_s.tmout = PWDATA[`CBX_ST_TMOUT];
					end
					`CBX_OFF_PC: begin
						// A new counter only takes while halted; the stale prefetch is dropped.
						if (!s.run) begin
							next_s.pc = {PWDATA[15:1], 1'b0};
							next_s.nop = 1'b1;
							next_s.kill = 1'b0;
						end
					end
					`CBX_OFF_WORK: next_s.work = PWDATA[7:0];
					default: ;
				endcase
			end
		end
		// The sequencer follows the bus so that a flag set by an instruction wins over a software write.
		if (s.run) begin
			case (s.phase)
				cbx_pkg::CBX_Q1: begin
					next_s.phase = cbx_pkg::CBX_Q2;
					if (cbx_pkg::uses_file(dec.op)) begin
						next_s.faddr = file_addr;
						next_s.frd = 1'b1;
					end
				end
				cbx_pkg::CBX_Q2: begin
					next_s.phase = cbx_pkg::CBX_Q3;
					next_s.frd = 1'b0;
				end
				cbx_pkg::CBX_Q3: begin
					next_s.phase = cbx_pkg::CBX_Q4;
					case (dec.op)
						cbx_pkg::CBX_OP_JNOV: next_s.take = !s.ovf;
						cbx_pkg::CBX_OP_JNZ: next_s.take = !s.zero;
						cbx_pkg::CBX_OP_JRA: next_s.take = 1'b1;
						cbx_pkg::CBX_OP_BSET: begin
							next_s.fwdata = FILE_RD_DATA | mask;
							next_s.fwr = 1'b1;
						end
						cbx_pkg::CBX_OP_TSC: next_s.skip = !FILE_RD_DATA[dec.bit_idx];
						cbx_pkg::CBX_OP_TSS: next_s.skip = FILE_RD_DATA[dec.bit_idx];
						cbx_pkg::CBX_OP_CPL: begin
							next_s.fwdata = ~FILE_RD_DATA;
							next_s.fwr = dec.dest;
						end
						cbx_pkg::CBX_OP_WDC: next_s.wdclr = 1'b1;
						default: ;
					endcase
				end
				cbx_pkg::CBX_Q4: begin
					next_s.phase = cbx_pkg::CBX_Q1;
					next_s.fwr = 1'b0;
					next_s.wdclr = 1'b0;
					next_s.take = 1'b0;
					next_s.skip = 1'b0;
					if (dec.op == cbx_pkg::CBX_OP_CPL) begin
						if (!dec.dest) begin
							next_s.work = s.fwdata;
						end
						next_s.neg = s.fwdata[7];
						next_s.zero = (s.fwdata == 8'h00);
					end
					if (dec.op == cbx_pkg::CBX_OP_WDC) begin
						next_s.tmout = 1'b1;
						next_s.pwrdn = 1'b1;
					end
					next_s.ir = PROG_DATA;
					if (s.take) begin
						next_s.pc = jump_target;
						next_s.nop = 1'b1;
						next_s.kill = 1'b0;
					end else begin
						next_s.pc = s.pc + `CBX_FETCH_STEP;
						if (s.skip) begin
							next_s.nop = 1'b1;
							next_s.kill = cbx_pkg::two_word(PROG_DATA);
						end else if (s.kill) begin
							next_s.nop = 1'b1;
							next_s.kill = 1'b0;
						end else begin
							next_s.nop = 1'b0;
						end
					end
				end
				default: next_s.phase = cbx_pkg::CBX_Q1;
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s <= '0;
			s.phase <= cbx_pkg::CBX_Q1;
			s.pc <= `CBX_RST_PC;
			s.bank <= `CBX_RST_BANK;
			s.tmout <= `CBX_RST_TMOUT;
			s.pwrdn <= `CBX_RST_PWRDN;
			s.nop <= 1'b1;
		end else if (CE) begin
			s <= next_s;
		end
	end

	assign PRDATA = s.prdata;
	assign PREADY = s.ready;
	assign PSLVERR = s.slverr;
	assign PROG_ADDR = s.pc;
	assign FILE_ADDR = s.faddr;
	assign FILE_RD_EN = s.frd;
	assign FILE_WR_EN = s.fwr;
	assign FILE_WR_DATA = s.fwdata;
	assign WATCHDOG_CLEAR = s.wdclr;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST || !CE);

	property p_jnov;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_JNOV) |=> (s.take == !$past(s.ovf));
	endproperty
	a_jnov: assert property (p_jnov) else $error("no-overflow jump decision wrong");

	property p_jnz;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_JNZ) |=> (s.take == !$past(s.zero));
	endproperty
	a_jnz: assert property (p_jnz) else $error("nonzero jump decision wrong");

	property p_target;
		(s.run && s.phase == cbx_pkg::CBX_Q4 && s.take) |=> (s.pc == $past(jump_target));
	endproperty
	a_target: assert property (p_target) else $error("jump target wrong");

	property p_jump_idle;
		(s.run && s.phase == cbx_pkg::CBX_Q4 && s.take) |=> s.nop [*4] ##1 !s.nop;
	endproperty
	a_jump_idle: assert property (p_jump_idle) else $error("taken jump idle cycle wrong");

	property p_nojump;
		(s.run && s.phase == cbx_pkg::CBX_Q4 && !s.take &&
			(dec.op == cbx_pkg::CBX_OP_JNOV || dec.op == cbx_pkg::CBX_OP_JNZ)) |=> !s.nop;
	endproperty
	a_nojump: assert property (p_nojump) else $error("untaken jump lost a cycle");

	property p_jra;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_JRA && !apb_done)
			|=> s.take ##1 (flags == $past(flags, 2));
	endproperty
	a_jra: assert property (p_jra) else $error("relative jump not taken or flags changed");

	property p_bset;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_BSET)
			|=> FILE_WR_EN && (FILE_WR_DATA == ($past(FILE_RD_DATA) | $past(mask)));
	endproperty
	a_bset: assert property (p_bset) else $error("bit set result wrong");

	property p_bank;
		(s.run && s.phase == cbx_pkg::CBX_Q1 && cbx_pkg::uses_file(dec.op)) |=> FILE_RD_EN &&
			(FILE_ADDR[7:0] == $past(s.ir[7:0])) &&
			(FILE_ADDR[11:8] == ($past(s.ir[8]) ? $past(s.bank) : {4{$past(s.ir[7])}}));
	endproperty
	a_bank: assert property (p_bank) else $error("file address banking wrong");

	property p_tsc;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_TSC) |=>
			(s.skip == !$past(FILE_RD_DATA[dec.bit_idx]));
	endproperty
	a_tsc: assert property (p_tsc) else $error("skip on clear decision wrong");

	property p_tss;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_TSS) |=>
			(s.skip == $past(FILE_RD_DATA[dec.bit_idx]));
	endproperty
	a_tss: assert property (p_tss) else $error("skip on set decision wrong");

	property p_skip_two;
		(s.run && s.phase == cbx_pkg::CBX_Q4 && s.skip && cbx_pkg::two_word(PROG_DATA)) |=> s.nop [*8] ##1 !s.nop;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("two-word skip length wrong");

	property p_wdc;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_WDC) |=>
			WATCHDOG_CLEAR ##1 (!WATCHDOG_CLEAR && s.tmout && s.pwrdn);
	endproperty
	a_wdc: assert property (p_wdc) else $error("watchdog clear effects wrong");

	property p_cpl;
		(s.run && s.phase == cbx_pkg::CBX_Q3 && dec.op == cbx_pkg::CBX_OP_CPL) |=>
			(FILE_WR_DATA == ~$past(FILE_RD_DATA)) && (FILE_WR_EN == $past(s.ir[9]));
	endproperty
	a_cpl: assert property (p_cpl) else $error("complement result or destination wrong");

	property p_wr_phase;
		FILE_WR_EN |-> (s.phase == cbx_pkg::CBX_Q4);
	endproperty
	a_wr_phase: assert property (p_wr_phase) else $error("file write outside fourth phase");

	property p_cpl_flags;
		(s.run && s.phase == cbx_pkg::CBX_Q4 && dec.op == cbx_pkg::CBX_OP_CPL) |=>
			(s.neg == $past(FILE_WR_DATA[7])) && (s.zero == ($past(FILE_WR_DATA) == 8'h00));
	endproperty
	a_cpl_flags: assert property (p_cpl_flags) else $error("complement flags wrong");

	c_jump: cover property (s.run && s.phase == cbx_pkg::CBX_Q4 && s.take);
	c_skip_two: cover property (s.run && s.phase == cbx_pkg::CBX_Q4 && s.skip && cbx_pkg::two_word(PROG_DATA));
	c_cpl_work: cover property (s.phase == cbx_pkg::CBX_Q4 && dec.op == cbx_pkg::CBX_OP_CPL && !dec.dest);

endmodule

// [tb/cbx_partner.sv]
`timescale 1ns/1ps

// ****************************************************************
// Program memory and data file seen from the core
// ****************************************************************
module cbx_partner (
	// Clock
	input wire logic clk,
	// Program fetch
	input wire logic [15:0] prog_addr,
	output logic [15:0] prog_data,
	// Data file
	input wire logic [11:0] file_addr,
	input wire logic file_rd_en,
	output logic [7:0] file_rd_data,
	input wire logic file_wr_en,
	input wire logic [7:0] file_wr_data
);
	logic [15:0] prog [0:63];
	logic [7:0] ram [0:4095];
	logic rd_q = 1'b0;

	assign prog_data = prog[prog_addr[6:1]];

	// Read data is only promised in the cycle after the strobe, so any other
	// cycle shows the inverse to catch a core that samples too early or late.
	always @(posedge clk) begin
		rd_q <= file_rd_en;
		if (file_wr_en === 1'b1) begin
			ram[file_addr] <= file_wr_data;
		end
	end
	assign file_rd_data = rd_q ? ram[file_addr] : ~ram[file_addr];
endmodule

// [tb/tb_cpu_branch_bit_skip_exec.sv]
`timescale 1ns/1ps
`include "cbx_params.svh"

module tb_cpu_branch_bit_skip_exec;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] prog_addr;
	logic [15:0] prog_data;
	logic [11:0] file_addr;
	logic file_rd_en;
	logic [7:0] file_rd_data;
	logic file_wr_en;
	logic [7:0] file_wr_data;
	logic wd_clear;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int stamps[$];
	logic [31:0] rd;
	logic er;
	// Sections are fenced by watchdog clears so each section's length shows as a gap.
	logic [15:0] img [24] = '{16'h0004, 16'hE501, 16'h8B40, 16'h0004, 16'h1C20, 16'hE101, 16'h8340,
		16'h0004, 16'h1E85, 16'hE101, 16'h8F40, 16'h0004, 16'hB285, 16'hC000, 16'h8740, 16'hA285,
		16'h8540, 16'hA485, 16'h8940, 16'h0004, 16'hD001, 16'h8D40, 16'h0004, 16'hD7FF};
	int gap [5] = '{12, 16, 16, 32, 12};

	cbx_core uut (
		.SYS_CLK(clk), .SYS_RST(rst), .CE(1'b1),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
		.FILE_ADDR(file_addr), .FILE_RD_EN(file_rd_en), .FILE_RD_DATA(file_rd_data),
		.FILE_WR_EN(file_wr_en), .FILE_WR_DATA(file_wr_data), .WATCHDOG_CLEAR(wd_clear)
	);

	cbx_partner mem (
		.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
		.file_addr(file_addr), .file_rd_en(file_rd_en), .file_rd_data(file_rd_data),
		.file_wr_en(file_wr_en), .file_wr_data(file_wr_data)
	);

	// ****************************************************************
	// Clock, watchdog pulse stamps and timeout
	// ****************************************************************
	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(negedge clk) begin
		cyc++;
		if (wd_clear === 1'b1) begin
			stamps.push_back(cyc);
		end
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		conclude();
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	// The request is held through the edge at which ready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		int n;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `CBX_OFF_STATUS, 32'h0);
		check(rd, 32'h00000018);
		apb(1'b1, `CBX_OFF_PC, 32'h00000001);
		apb(1'b0, `CBX_OFF_PC, 32'h0);
		check(rd, 32'h00000000);
		apb(1'b0, 8'h14, 32'h0);
		check({31'h0, er}, 32'h00000001);
		check(rd, 32'h00000000);
		$display("Test register access done");
		for (int i = 0; i < 24; i++) begin
			mem.prog[i] = img[i];
		end
		mem.ram[12'h020] = 8'hFF;
		mem.ram[12'h340] = 8'h00;
		mem.ram[12'hF85] = 8'h02;
		apb(1'b1, `CBX_OFF_STATUS, 32'h0);
		apb(1'b1, `CBX_OFF_WORK, 32'h0000005A);
		apb(1'b1, `CBX_OFF_CTRL, 32'h00000301);
		n = 0;
		while (stamps.size() < 6 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		// Halting freezes the sequencer, so the stop must land after the idle cycle of the self-jump.
		repeat (4) @(posedge clk);
		apb(1'b1, `CBX_OFF_CTRL, 32'h00000300);
		check(32'(stamps.size()), 32'd6);
		if (stamps.size() >= 6) begin
			for (int i = 0; i < 5; i++) begin
				check(32'(stamps[i + 1] - stamps[i]), 32'(gap[i]));
			end
		end
		$display("Test instruction timing done");
		check({24'h0, mem.ram[12'h340]}, 32'h00000006);
		check({24'h0, mem.ram[12'h020]}, 32'h000000FF);
		check({24'h0, mem.ram[12'hF85]}, 32'h000000FD);
		apb(1'b0, `CBX_OFF_WORK, 32'h0);
		check(rd, 32'h00000000);
		apb(1'b0, `CBX_OFF_STATUS, 32'h0);
		check(rd, 32'h0000001C);
		$display("Test results done");
		conclude();
	end
endmodule
